// >>> pbs_map.svh
// register offsets, field positions and mode codes for the port b low function select
`ifndef PBS_MAP_SVH
`define PBS_MAP_SVH

`define PBS_SEL_INDEX      32'h05FFFFCE
`define PBS_SEL_ADDR       32'h17FFFF38
`define PBS_ADDR_MASK      32'h0000FFFF
`define PBS_SEL_RESET      16'h0000
`define PBS_PAD_RESET      8'h00
`define PBS_OWN_RESET      8'hFF
`define PBS_SEL_WIDTH      16
`define PBS_PINS           8
`define PBS_MODE_GPIO      2'h0
`define PBS_MODE_ALT1      2'h1
`define PBS_MODE_ALT2      2'h2
`define PBS_MODE_ALT3      2'h3
`define PBS_PIN7           7
`define PBS_PIN6           6
`define PBS_PIN5           5
`define PBS_PIN4           4
`define PBS_PIN4_LO        8
`define PBS_PIN4_HI        9

`endif

// >>> pbs_pkg.sv
// types shared by the port b low function select block
package pbs_pkg;

    typedef enum logic [1:0] {
        pbs_fn_gpio,
        pbs_fn_alt1,
        pbs_fn_alt2,
        pbs_fn_alt3
    } pbs_fn_type;

    // per-pin routing toward the pad
    typedef struct packed {
        logic out_val;
        logic out_en;
        logic gpio_owned;
    } pbs_pad_type;

    // signals coming back from the alternate units for one pin
    typedef struct packed {
        logic pattern_val;
        logic timer_val;
        logic timer_oe;
    } pbs_alt_type;

endpackage : pbs_pkg

// >>> pbs_pin_route.sv
// one pin's multiplexer between general-purpose port logic and alternate units
`timescale 1ns/1ps
`include "pbs_map.svh"

module pbs_pin_route #(
    parameter bit HAS_CLK_IN  = 1'b0,   // code 01 selects a timer clock input when ALT1_VALID is also set
    parameter bit ALT1_VALID  = 1'b0    // code 01 is a real function here
) (
    input  wire logic [1:0]          mode,      // two-bit mode field
    input  wire logic                gpio_val,  // port data bit
    input  wire logic                gpio_oe,   // port direction bit
    input  wire pbs_pkg::pbs_alt_type alt,      // alternate unit signals
    input  wire logic                pad_in,    // level seen at the pad
    output pbs_pkg::pbs_pad_type     pad,       // drive toward the pad
    output logic                     clk_in     // pad forwarded to timer clock
);

    always_comb begin
        pad.out_val    = 1'b0;
        pad.out_en     = 1'b0;
        pad.gpio_owned = 1'b0;
        clk_in         = 1'b0;
        case (mode)
            `PBS_MODE_GPIO: begin
                pad.out_val    = gpio_val;
                pad.out_en     = gpio_oe;
                pad.gpio_owned = 1'b1;
            end
            `PBS_MODE_ALT1: begin
                // input only; reserved code leaves the pad undriven
                clk_in = (HAS_CLK_IN && ALT1_VALID) ? pad_in : 1'b0;
            end
            `PBS_MODE_ALT2: begin
                pad.out_val = alt.timer_val;
                pad.out_en  = alt.timer_oe;
            end
            `PBS_MODE_ALT3: begin
                pad.out_val = alt.pattern_val;
                pad.out_en  = 1'b1;
            end
            default: begin
                pad.gpio_owned = 1'b1;
            end
        endcase
    end

endmodule : pbs_pin_route

// >>> pbs_select.sv
// apb register and pin routing for port b pins 7 to 0
`timescale 1ns/1ps
`include "pbs_map.svh"

module pbs_select (
    input  wire logic        pclk,                   // system clock
    input  wire logic        presetn,                // async reset, low active
    input  wire logic        psel,                   // apb select
    input  wire logic        penable,                // apb access phase
    input  wire logic        pwrite,                 // apb direction
    input  wire logic [31:0] paddr,                  // apb byte address
    input  wire logic [31:0] pwdata,                 // apb write data
    input  wire logic [3:0]  pstrb,                  // apb byte strobes
    output logic      [31:0] prdata,                 // apb read data
    output logic             pready,                 // apb ready
    output logic             pslverr,                // apb error
    input  wire logic [7:0]  gpio_val,               // port data bits
    input  wire logic [7:0]  gpio_oe,                // port direction bits
    input  wire logic [7:0]  pad_in,                 // pad levels
    input  wire logic [7:0]  timer_val,              // timer pin values per pin
    input  wire logic [7:0]  timer_oe,               // timer pin enables per pin
    input  wire logic [7:0]  pattern_bit,            // pattern unit bits 7..0
    output logic      [7:0]  pad_out,                // pad output value
    output logic      [7:0]  pad_oe,                 // pad output enable
    output logic      [7:0]  gpio_owned,             // pin belongs to port logic
    output logic             timer_ext_clock_d,      // pin 7 to timer clock d
    output logic             timer_ext_clock_c,      // pin 6 to timer clock c
    output logic      [15:0] port_b_low_function_select // current field value
);

    localparam int PINS = `PBS_PINS;

    logic [15:0] sel_reg;
    logic [15:0] sel_next;
    logic        ready_reg;
    logic        ready_next;
    logic        err_reg;
    logic        err_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    logic [7:0]  route_out;
    logic [7:0]  route_oe;
    logic [7:0]  route_own;
    logic [7:0]  route_clk;

    logic [7:0]  pad_out_reg;
    logic [7:0]  pad_oe_reg;
    logic [7:0]  own_reg;
    logic        clkd_reg;
    logic        clkc_reg;
    logic [7:0]  pad_out_next;
    logic [7:0]  pad_oe_next;
    logic [7:0]  own_next;
    logic        clkd_next;
    logic        clkc_next;

    // only the low half of the byte address is decoded, so the register aliases
    function automatic logic addr_hit(input logic [31:0] a);
        addr_hit = ((a & `PBS_ADDR_MASK) == (`PBS_SEL_ADDR & `PBS_ADDR_MASK));
    endfunction : addr_hit

    function automatic logic [1:0] field_of(input logic [15:0] r, input int pin);
        field_of = r[2*pin +: 2];
    endfunction : field_of

    // zero-wait-state slave: ready comes in the first access cycle
    always_comb begin
        sel_next   = sel_reg;
        ready_next = 1'b0;
        err_next   = 1'b0;
        rdata_next = rdata_reg;
        if (psel && !penable) begin
            ready_next = 1'b1;
            err_next   = !addr_hit(paddr);
            rdata_next = 32'h00000000;
            if (!pwrite && addr_hit(paddr)) begin
                rdata_next = {16'h0000, sel_reg};
            end
        end
        if (psel && penable && ready_reg && pwrite && addr_hit(paddr)) begin
            // byte lanes map low and high field halves
            if (pstrb[0]) begin
                sel_next[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                sel_next[15:8] = pwdata[15:8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg   <= `PBS_SEL_RESET;
            ready_reg <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            sel_reg   <= sel_next;
            ready_reg <= ready_next;
            err_reg   <= err_next;
            rdata_reg <= rdata_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            pbs_pkg::pbs_alt_type alt;
            pbs_pkg::pbs_pad_type pad;
            assign alt.pattern_val = pattern_bit[g];
            assign alt.timer_val   = timer_val[g];
            assign alt.timer_oe    = timer_oe[g];
            pbs_pin_route #(
                .HAS_CLK_IN (g == `PBS_PIN7 || g == `PBS_PIN6),
                .ALT1_VALID (g == `PBS_PIN7 || g == `PBS_PIN6)
            ) u_route (
                .mode     (field_of(sel_reg, g)),
                .gpio_val (gpio_val[g]),
                .gpio_oe  (gpio_oe[g]),
                .alt      (alt),
                .pad_in   (pad_in[g]),
                .pad      (pad),
                .clk_in   (route_clk[g])
            );
            assign route_out[g] = pad.out_val;
            assign route_oe[g]  = pad.out_en;
            assign route_own[g] = pad.gpio_owned;
        end
    endgenerate

    // registered pad side; adds one cycle of latency to every route
    always_comb begin
        pad_out_next = route_out;
        pad_oe_next  = route_oe;
        // pin 4 follows its field like the rest
        own_next     = route_own;
        clkd_next    = route_clk[`PBS_PIN7];
        clkc_next    = route_clk[`PBS_PIN6];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out_reg <= `PBS_PAD_RESET;
            pad_oe_reg  <= `PBS_PAD_RESET;
            own_reg     <= `PBS_OWN_RESET;
            clkd_reg    <= 1'b0;
            clkc_reg    <= 1'b0;
        end else begin
            pad_out_reg <= pad_out_next;
            pad_oe_reg  <= pad_oe_next;
            own_reg     <= own_next;
            clkd_reg    <= clkd_next;
            clkc_reg    <= clkc_next;
        end
    end

    assign prdata                     = rdata_reg;
    assign pready                     = ready_reg;
    assign pslverr                    = err_reg;
    assign pad_out                    = pad_out_reg;
    assign pad_oe                     = pad_oe_reg;
    assign gpio_owned                 = own_reg;
    assign timer_ext_clock_d          = clkd_reg;
    assign timer_ext_clock_c          = clkc_reg;
    assign port_b_low_function_select = sel_reg;

endmodule : pbs_select

// >>> pbs_unit_model.sv
// model of the timer and timing pattern units feeding the pin routing
`timescale 1ns/1ps
module pbs_unit_model (
    input  wire logic       pclk,        // clock
    input  wire logic [7:0] pat_set,     // pattern to emit
    output logic      [7:0] pattern_bit, // pattern bits
    output logic      [7:0] timer_val,   // timer pin values
    output logic      [7:0] timer_oe     // timer pin enables
);
    // outputs move only at the clock edge, as the real units do
    always_ff @(posedge pclk) begin
        pattern_bit <= pat_set;
        timer_val   <= ~pat_set;
        // enable differs from value unless the pattern nibbles are complements, as 8'hA5 is
        timer_oe    <= {pat_set[3:0], pat_set[7:4]};
    end
endmodule : pbs_unit_model

// >>> pbs_select_chk.sv
// assertions on the port b low function select ports
`timescale 1ns/1ps
module pbs_select_chk (
    input wire logic        pclk,              // clock
    input wire logic        presetn,           // reset
    input wire logic        psel,              // select
    input wire logic        penable,           // access
    input wire logic        pwrite,            // direction
    input wire logic [31:0] pwdata,            // write data
    input wire logic [3:0]  pstrb,             // strobes
    input wire logic [31:0] prdata,            // read data
    input wire logic        pready,            // ready
    input wire logic        pslverr,           // error
    input wire logic [7:0]  gpio_val,          // port data
    input wire logic [7:0]  gpio_oe,           // port dir
    input wire logic [7:0]  pad_in,            // pad levels
    input wire logic [7:0]  timer_val,         // timer value
    input wire logic [7:0]  timer_oe,          // timer enable
    input wire logic [7:0]  pattern_bit,       // pattern
    input wire logic [7:0]  pad_out,           // pad value
    input wire logic [7:0]  pad_oe,            // pad enable
    input wire logic [7:0]  gpio_owned,        // port owns pin
    input wire logic        timer_ext_clock_d, // clock d
    input wire logic [15:0] port_b_low_function_select // register
);
    logic [15:0] sel;
    logic [7:0]  own_exp;
    logic        acc;
    assign sel = port_b_low_function_select;
    assign acc = psel && penable && pready;
    always_comb for (int i = 0; i < 8; i++) own_exp[i] = sel[2*i+:2] == 2'h0;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rst; $rose(presetn) |-> sel == 16'h0000 && gpio_owned == 8'hFF; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_wr; acc && pwrite && !pslverr && pstrb[1:0] == 2'h3 |=> sel == $past(pwdata[15:0]);
    endproperty
    a_wr: assert property (p_wr) else $error("write lost");
    property p_rd; acc && !pwrite && !pslverr |-> prdata == {16'h0000, sel}; endproperty
    a_rd: assert property (p_rd) else $error("read value");
    property p_own; 1'b1 |=> gpio_owned == $past(own_exp); endproperty
    a_own: assert property (p_own) else $error("ownership");
    property p_gp4; sel[9:8] == 2'h0 |=> {pad_oe[4], pad_out[4]} == $past({gpio_oe[4], gpio_val[4]});
    endproperty
    a_gp4: assert property (p_gp4) else $error("pin 4 port");
    property p_clkd; sel[15:14] == 2'h1 |=> timer_ext_clock_d == $past(pad_in[7]) && !pad_oe[7];
    endproperty
    a_clkd: assert property (p_clkd) else $error("clock d");
    property p_cmpb; sel[15:14] == 2'h2 |=> {pad_oe[7], pad_out[7]} == $past({timer_oe[7], timer_val[7]});
    endproperty
    a_cmpb: assert property (p_cmpb) else $error("compare b");
    property p_pat7; sel[15:14] == 2'h3 |=> pad_oe[7] && pad_out[7] == $past(pattern_bit[7]); endproperty
    a_pat7: assert property (p_pat7) else $error("pattern 7");
    property p_rsv5; sel[11:10] == 2'h1 |=> !pad_oe[5] && !gpio_owned[5]; endproperty
    a_rsv5: assert property (p_rsv5) else $error("pin 5 reserved");
    c_miss: cover property (acc && pslverr);
    c_wr: cover property (acc && pwrite);
    c_pat: cover property (sel[15:14] == 2'h3);
endmodule : pbs_select_chk
bind pbs_select pbs_select_chk u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .gpio_val, .gpio_oe, .pad_in, .timer_val, .timer_oe, .pattern_bit, .pad_out, .pad_oe,
    .gpio_owned, .timer_ext_clock_d, .port_b_low_function_select);

// >>> tb_top.sv
// testbench for the port b low function select block
`timescale 1ns/1ps
`include "pbs_map.svh"
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, err, timer_ext_clock_d, timer_ext_clock_c;
    logic [7:0]  gpio_val = 8'h3C, gpio_oe = 8'hF0, pad_in = 8'h80, pat = 8'hA5;
    logic [7:0]  timer_val, timer_oe, pattern_bit, pad_out, pad_oe, gpio_owned;
    logic [15:0] port_b_low_function_select;
    int          error_cnt = 0, cmp_count = 0, cyc = 0;
    // field value, pad enable, driven value, ownership, clocks d and c
    logic [41:0] rows [6] = '{
        {16'h0000, 8'hF0, 8'h30, 8'hFF, 2'h0}, {16'hFFFF, 8'hFF, 8'hA5, 8'h00, 2'h0},
        {16'hAAAA, 8'h5A, 8'h5A, 8'h00, 2'h0}, {16'h5000, 8'h30, 8'h30, 8'h3F, 2'h2},
        {16'h0500, 8'hC0, 8'h00, 8'hCF, 2'h0}, {16'hE400, 8'hD0, 8'hD0, 8'h1F, 2'h0}};
    always #20 pclk = ~pclk;
    pbs_unit_model u_model (.pclk, .pat_set(pat), .pattern_bit, .timer_val, .timer_oe);
    pbs_select u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .gpio_val, .gpio_oe, .pad_in, .timer_val, .timer_oe,
        .pattern_bit, .pad_out, .pad_oe, .gpio_owned, .timer_ext_clock_d, .timer_ext_clock_c,
        .port_b_low_function_select);
    task automatic chk(input string n, input logic [41:0] e, input logic [41:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
    endtask : apb
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask : idle
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    // cut a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            // upper half is not part of the register
            apb(1'b1, `PBS_SEL_ADDR, {16'hFFFF, rows[i][41:26]});
            apb(1'b0, `PBS_SEL_ADDR, 32'h0);
            idle(3);
            chk("readback", {26'h0, rows[i][41:26]}, {10'h000, rd});
            chk("pins", rows[i][25:0], {16'h0000, pad_oe, pad_out & pad_oe, gpio_owned,
                timer_ext_clock_d, timer_ext_clock_c});
            $display("row %0d done", i);
        end
        apb(1'b1, `PBS_SEL_ADDR + 32'h4, 32'h0000FFFF);
        chk("miss error", 42'h1, {41'h0, err});
        apb(1'b0, `PBS_SEL_ADDR + 32'h4, 32'h0);
        chk("miss data", 42'h0, {10'h000, rd});
        apb(1'b0, `PBS_SEL_ADDR, 32'h0);
        chk("kept", 42'hE400, {10'h000, rd});
        $display("miss done");
        // upper lane only; the low field half must survive
        pstrb <= 4'h2;
        apb(1'b1, `PBS_SEL_ADDR, 32'h00001B2C);
        pstrb <= 4'hF;
        apb(1'b0, `PBS_SEL_ADDR, 32'h0);
        chk("lane write", 42'h1B00, {10'h000, rd});
        chk("register", 42'h1B00, {26'h0, port_b_low_function_select});
        pad_in <= 8'h40;
        apb(1'b1, `PBS_SEL_ADDR, 32'h00005000);
        idle(3);
        chk("clock c", 42'h1, {40'h0, timer_ext_clock_d, timer_ext_clock_c});
        $display("lane done");
        presetn <= 1'b0;
        idle(2);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `PBS_SEL_ADDR, 32'h0);
        idle(1);
        chk("reset value", 42'h0, {10'h000, rd});
        chk("reset owner", 42'hFF, {34'h0, gpio_owned});
        $display("reset done");
        end_sim();
    end
endmodule : tb_top
